// ### src/ppc_pkg.sv
/*
 * Constants and carrier types for the port pin control block.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
// Summary of operation
// RQ1: GPIO output drives port T data bit
// RQ2: Port T read: data if output, else pin
// RQ3: Bit 5 priority timer, PWM, regulator, GPIO
// RQ4: Enabled timer channel overrides port T bits 3-0
// RQ5: Input register always reads buffered pin state
// RQ6: Writes to input register are ignored
// RQ7: Open-drain: drive low on 0, release on 1
// RQ8: Open-drain select ignored for input pins
// RQ9: Port P direction 1 output, 0 input
// RQ10: Enabled PWM channel forces port P output
// RQ11: PWM shutdown forces port P bit 7 input
// RQ12: Bits 2,1,0: timer compare forces output
// RQ13: Bits 2,0: serial interface sets direction
// RQ14: Overrides never modify stored direction bits
// RQ15: Routing register moves serial and SPI pins
// RQ16: Override output carries peripheral value
package ppc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_PORT_T_DATA  = 8'h00;
    localparam logic [7:0] OFS_PORT_T_DIR   = 8'h04;
    localparam logic [7:0] OFS_PORT_T_INPUT = 8'h08;
    localparam logic [7:0] OFS_PORT_M_OD    = 8'h0c;
    localparam logic [7:0] OFS_ROUTING      = 8'h10;
    localparam logic [7:0] OFS_PORT_P_DATA  = 8'h14;
    localparam logic [7:0] OFS_PORT_P_DIR   = 8'h18;
    localparam logic [7:0] OFS_PORT_M_DATA  = 8'h1c;
    localparam logic [7:0] OFS_PORT_M_DIR   = 8'h20;
    localparam logic [7:0] OFS_PERIPH_CTRL  = 8'h24;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Field positions
    localparam int BIT_T_SHARED  = 5;
    localparam int BIT_P_SHUT    = 7;
    localparam int BIT_ROUTE_TX  = 7;
    localparam int BIT_ROUTE_RX  = 6;
    localparam int BIT_CTRL_REG  = 0;
    localparam int BIT_CTRL_SHUT = 1;
    localparam int BIT_CTRL_PWMT = 2;
    localparam int BIT_P_RX      = 0;
    localparam int BIT_P_TX      = 2;
    localparam int BIT_P_OC_TOP  = 2;

    // Wishbone request bundle
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } ppc_wb_req_t;

    // Peripheral drive bundle for one 8-bit port
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] val;
    } ppc_periph_t;

    // Pin bundle towards the pad ring
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } ppc_pad_t;

endpackage

// ### src/ppc_pin_sync.sv
/*
 * Two-stage synchroniser for one 8-bit group of pad inputs.
 * Assumes pad levels are asynchronous to core_clk.
 */
`timescale 1ns/100ps
module ppc_pin_sync
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] pin_async,
    output logic      [7:0] pin_sync
);

    logic [7:0] stage_one;

    ////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            stage_one <= ppc_pkg::RST_BYTE;
            pin_sync  <= ppc_pkg::RST_BYTE;
        end
        else
        begin
            stage_one <= pin_async;
            pin_sync  <= stage_one;
        end
    end

endmodule

// ### src/ppc_port_ctrl.sv
/*
 * Pin control for ports T, P and M with a Wishbone register slave.
 * Assumes peripheral enables and values are synchronous to core_clk
 * and that pad inputs are asynchronous.
 */
`timescale 1ns/100ps
module ppc_port_ctrl
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // Wishbone slave
    input  wire ppc_pkg::ppc_wb_req_t wb_req,
    output logic               [31:0] wb_dat_o,
    output logic                      wb_ack_o,
    // Port T pads and functions
    input  wire logic           [7:0] port_t_pin_in,
    output ppc_pkg::ppc_pad_t         port_t_pad,
    input  wire ppc_pkg::ppc_periph_t timer_t_out,
    input  wire logic                 pwm_t5_en,
    input  wire logic                 pwm_t5_val,
    input  wire logic                 reg_api_val,
    // Port P pads and functions
    input  wire logic           [7:0] port_p_pin_in,
    output ppc_pkg::ppc_pad_t         port_p_pad,
    input  wire ppc_pkg::ppc_periph_t pwm_p_out,
    input  wire ppc_pkg::ppc_periph_t timer_p_oc,
    input  wire logic                 serial_en,
    input  wire logic                 serial_tx_val,
    // Port M pads, open-drain capable
    input  wire logic           [7:0] port_m_pin_in,
    output ppc_pkg::ppc_pad_t         port_m_pad,
    input  wire ppc_pkg::ppc_periph_t periph_m_out,
    // Routing and synchronised pin views
    output logic                      serial_tx_alt,
    output logic                      serial_rx_alt,
    output logic                [7:0] peripheral_pin_routing,
    output logic                [7:0] port_t_in_sync,
    output logic                [7:0] port_p_in_sync
);

    logic [7:0] port_t_data_bits;
    logic [7:0] port_t_dir;
    logic [7:0] port_m_open_drain_select;
    logic [7:0] port_p_data;
    logic [7:0] port_p_direction_bits;
    logic [7:0] port_m_data;
    logic [7:0] port_m_dir;
    logic [2:0] periph_ctrl;
    logic [7:0] port_m_in_sync;
    logic [7:0] t_drv_en;
    logic [7:0] t_drv_val;
    logic [7:0] p_drv_en;
    logic [7:0] p_drv_val;
    logic [7:0] m_out_val;
    logic [7:0] m_oe;
    logic [7:0] next_rd;
    logic       wb_hit;
    logic       wb_wr;

    ////////////////////////////////////////////////////////////////////////
    // Merge a write into a byte register under lane 0
    function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0] sel);
        wr_byte = sel[0] ? dat[7:0] : old;
    endfunction

    // Read-back: stored bit when output, pin otherwise
    function automatic logic [7:0] rd_mix(input logic [7:0] data,
                                          input logic [7:0] dir,
                                          input logic [7:0] pin);
        rd_mix = (data & dir) | (pin & ~dir);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pad input synchronisers
    ppc_pin_sync u_sync_t
    (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_async (port_t_pin_in),
        .pin_sync  (port_t_in_sync)
    );

    ppc_pin_sync u_sync_p
    (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_async (port_p_pin_in),
        .pin_sync  (port_p_in_sync)
    );

    ppc_pin_sync u_sync_m
    (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_async (port_m_pin_in),
        .pin_sync  (port_m_in_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus strobes: one-cycle ack, dropped after each beat
    assign wb_hit = wb_req.cyc & wb_req.stb & ~wb_ack_o;
    assign wb_wr  = wb_hit & wb_req.we;

    // Register writes; input register has no write path
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            port_t_data_bits         <= ppc_pkg::RST_BYTE;
            port_t_dir               <= ppc_pkg::RST_BYTE;
            port_m_open_drain_select <= ppc_pkg::RST_BYTE;
            peripheral_pin_routing   <= ppc_pkg::RST_BYTE;
            port_p_data              <= ppc_pkg::RST_BYTE;
            port_p_direction_bits    <= ppc_pkg::RST_BYTE;
            port_m_data              <= ppc_pkg::RST_BYTE;
            port_m_dir               <= ppc_pkg::RST_BYTE;
            periph_ctrl              <= ppc_pkg::RST_BYTE[2:0];
        end
        else if (wb_wr)
        begin
            case (wb_req.adr)
                ppc_pkg::OFS_PORT_T_DATA:
                    port_t_data_bits <= wr_byte(port_t_data_bits,
                                                wb_req.dat, wb_req.sel);
                ppc_pkg::OFS_PORT_T_DIR:
                    port_t_dir <= wr_byte(port_t_dir, wb_req.dat,
                                          wb_req.sel);
                ppc_pkg::OFS_PORT_M_OD:
                    port_m_open_drain_select <= wr_byte(
                        port_m_open_drain_select, wb_req.dat, wb_req.sel);
                ppc_pkg::OFS_ROUTING: // RQ15
                    peripheral_pin_routing <= wr_byte(
                        peripheral_pin_routing, wb_req.dat, wb_req.sel);
                ppc_pkg::OFS_PORT_P_DATA:
                    port_p_data <= wr_byte(port_p_data, wb_req.dat,
                                           wb_req.sel);
                ppc_pkg::OFS_PORT_P_DIR: // RQ14
                    port_p_direction_bits <= wr_byte(
                        port_p_direction_bits, wb_req.dat, wb_req.sel);
                ppc_pkg::OFS_PORT_M_DATA:
                    port_m_data <= wr_byte(port_m_data, wb_req.dat,
                                           wb_req.sel);
                ppc_pkg::OFS_PORT_M_DIR:
                    port_m_dir <= wr_byte(port_m_dir, wb_req.dat,
                                          wb_req.sel);
                ppc_pkg::OFS_PERIPH_CTRL:
                    if (wb_req.sel[0])
                    begin
                        periph_ctrl <= wb_req.dat[2:0];
                    end
                // Input register and unmapped offsets keep all state
                default:
                    port_t_dir <= port_t_dir; // RQ6
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port T source selection
    always_comb
    begin
        t_drv_en  = port_t_dir;
        t_drv_val = port_t_data_bits; // RQ1
        // Any enabled timer channel takes its pin first
        for (int i = 0; i < 8; i++)
        begin
            if (timer_t_out.en[i])
            begin
                t_drv_en[i]  = 1'b1; // RQ4
                t_drv_val[i] = timer_t_out.val[i]; // RQ16
            end
        end
        // Bit 5: timer, then routed PWM, then regulator, then GPIO
        if (!timer_t_out.en[ppc_pkg::BIT_T_SHARED])
        begin
            if (pwm_t5_en)
            begin
                t_drv_en[ppc_pkg::BIT_T_SHARED]  = 1'b1; // RQ3
                t_drv_val[ppc_pkg::BIT_T_SHARED] = pwm_t5_val;
            end
            else if (periph_ctrl[ppc_pkg::BIT_CTRL_REG])
            begin
                t_drv_en[ppc_pkg::BIT_T_SHARED]  = 1'b1; // RQ3
                t_drv_val[ppc_pkg::BIT_T_SHARED] = reg_api_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port P direction override chain
    always_comb
    begin
        p_drv_en  = port_p_direction_bits; // RQ9
        p_drv_val = port_p_data;
        // Priority: PWM, then timer compare, then serial
        for (int i = 0; i < 8; i++)
        begin
            if (pwm_p_out.en[i])
            begin
                p_drv_en[i]  = 1'b1; // RQ10
                p_drv_val[i] = pwm_p_out.val[i]; // RQ16
            end
            else if (i <= ppc_pkg::BIT_P_OC_TOP && timer_p_oc.en[i])
            begin
                p_drv_en[i]  = 1'b1; // RQ12
                p_drv_val[i] = timer_p_oc.val[i];
            end
            else if ((i == ppc_pkg::BIT_P_RX || i == ppc_pkg::BIT_P_TX)
                     && serial_en)
            begin
                // Transmit pin drives, receive pin is released
                p_drv_en[i]  = (i == ppc_pkg::BIT_P_TX); // RQ13
                p_drv_val[i] = serial_tx_val;
            end
        end
        // Shutdown comes last so it beats a PWM enable on bit 7
        if (periph_ctrl[ppc_pkg::BIT_CTRL_SHUT])
        begin
            p_drv_en[ppc_pkg::BIT_P_SHUT] = 1'b0; // RQ11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port M drive with optional open-drain
    always_comb
    begin
        // A peripheral enable makes the pin an output
        for (int i = 0; i < 8; i++)
        begin
            m_out_val[i] = periph_m_out.en[i] ? periph_m_out.val[i]
                                              : port_m_data[i];
            if (!(periph_m_out.en[i] | port_m_dir[i]))
            begin
                m_oe[i] = 1'b0; // RQ8
            end
            else if (port_m_open_drain_select[i])
            begin
                m_oe[i] = ~m_out_val[i]; // RQ7
            end
            else
            begin
                m_oe[i] = 1'b1;
            end
        end
    end

    // Pad outputs
    assign port_t_pad.out = t_drv_val;
    assign port_t_pad.oe  = t_drv_en;
    assign port_p_pad.out = p_drv_val;
    assign port_p_pad.oe  = p_drv_en;
    // Open-drain pins never drive a high level
    assign port_m_pad.out = m_out_val & ~port_m_open_drain_select;
    assign port_m_pad.oe  = m_oe;

    // Routing selects for the serial pins
    assign serial_tx_alt = peripheral_pin_routing[ppc_pkg::BIT_ROUTE_TX];
    assign serial_rx_alt = peripheral_pin_routing[ppc_pkg::BIT_ROUTE_RX];

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer
    always_comb
    begin
        case (wb_req.adr)
            ppc_pkg::OFS_PORT_T_DATA:
                next_rd = rd_mix(port_t_data_bits, port_t_dir,
                                 port_t_in_sync); // RQ2
            ppc_pkg::OFS_PORT_T_DIR:   next_rd = port_t_dir;
            ppc_pkg::OFS_PORT_T_INPUT: next_rd = port_t_in_sync; // RQ5
            ppc_pkg::OFS_PORT_M_OD:    next_rd = port_m_open_drain_select;
            ppc_pkg::OFS_ROUTING:      next_rd = peripheral_pin_routing;
            ppc_pkg::OFS_PORT_P_DATA:
                next_rd = rd_mix(port_p_data, port_p_direction_bits,
                                 port_p_in_sync);
            ppc_pkg::OFS_PORT_P_DIR:   next_rd = port_p_direction_bits;
            ppc_pkg::OFS_PORT_M_DATA:
                next_rd = rd_mix(port_m_data, port_m_dir, port_m_in_sync);
            ppc_pkg::OFS_PORT_M_DIR:   next_rd = port_m_dir;
            ppc_pkg::OFS_PERIPH_CTRL:  next_rd = {5'h00, periph_ctrl};
            // Unmapped offsets read zero and are still acked
            default:                   next_rd = 8'h00;
        endcase
    end

    // Ack and registered read data
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            // Ack lasts one cycle because a hit needs ack low
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? {24'h00_0000, next_rd} : 32'h0000_0000;
        end
    end

endmodule

// ### test/ppc_port_chk.sv
/*
 * Port-level checker for the port pin control block.
 * Bound to every ppc_port_ctrl; it sees only that module's ports.
 */
`timescale 1ns/100ps
module ppc_port_chk
(
    input logic                 core_clk,
    input logic                 rst_n,
    input ppc_pkg::ppc_wb_req_t wb_req,
    input logic          [31:0] wb_dat_o,
    input logic                 wb_ack_o,
    input logic           [7:0] port_t_pin_in,
    input ppc_pkg::ppc_pad_t    port_t_pad,
    input ppc_pkg::ppc_periph_t timer_t_out,
    input logic                 pwm_t5_en,
    input logic                 pwm_t5_val,
    input ppc_pkg::ppc_pad_t    port_p_pad,
    input ppc_pkg::ppc_periph_t pwm_p_out,
    input ppc_pkg::ppc_periph_t timer_p_oc,
    input logic                 serial_en,
    input logic                 serial_tx_val,
    input logic                 serial_tx_alt,
    input logic                 serial_rx_alt,
    input logic           [7:0] peripheral_pin_routing,
    input logic           [7:0] port_t_in_sync,
    input logic           [7:0] port_p_pin_in,
    input logic           [7:0] port_p_in_sync
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Request taken at this edge
    logic take;
    assign take = wb_req.cyc && wb_req.stb && !wb_ack_o;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake, routing write and pin sync delay
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (take |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    route_reg_a: assert property (
        take && wb_req.we && wb_req.sel[0] &&
        wb_req.adr == ppc_pkg::OFS_ROUTING |=>
        peripheral_pin_routing == $past(wb_req.dat[7:0]) &&
        {serial_tx_alt, serial_rx_alt} == $past(wb_req.dat[7:6]))
        else $error("routing register did not take write");
    pin_sync_a: assert property ($past(rst_n) && $past(rst_n, 2) |->
        {port_p_in_sync, port_t_in_sync} ==
        $past({port_p_pin_in, port_t_pin_in}, 2))
        else $error("pin view not two cycles behind pad");

    ////////////////////////////////////////////////////////////////////////
    // Pad overrides
    t_timer_a: assert property (
        (port_t_pad.oe[3:0] & timer_t_out.en[3:0]) == timer_t_out.en[3:0]
        && ((port_t_pad.out[3:0] ^ timer_t_out.val[3:0])
        & timer_t_out.en[3:0]) == 4'h0)
        else $error("timer does not own port T low pins");
    t5_timer_a: assert property (timer_t_out.en[5] |->
        port_t_pad.oe[5] && port_t_pad.out[5] == timer_t_out.val[5])
        else $error("timer not first on port T bit 5");
    t5_pwm_a: assert property (pwm_t5_en && !timer_t_out.en[5] |->
        port_t_pad.oe[5] && port_t_pad.out[5] == pwm_t5_val)
        else $error("PWM not second on port T bit 5");
    p_pwm_a: assert property (
        (port_p_pad.oe[6:0] & pwm_p_out.en[6:0]) == pwm_p_out.en[6:0]
        && ((port_p_pad.out[6:0] ^ pwm_p_out.val[6:0])
        & pwm_p_out.en[6:0]) == 7'h0)
        else $error("PWM does not own port P pin");
    p_timer_a: assert property (
        timer_p_oc.en[1] && !pwm_p_out.en[1] |->
        port_p_pad.oe[1] && port_p_pad.out[1] == timer_p_oc.val[1])
        else $error("timer compare does not own port P bit 1");
    p_serial_a: assert property (serial_en && !pwm_p_out.en[2] &&
        !timer_p_oc.en[2] && !pwm_p_out.en[0] && !timer_p_oc.en[0] |->
        port_p_pad.oe[2] && port_p_pad.out[2] == serial_tx_val
        && !port_p_pad.oe[0])
        else $error("serial does not set port P directions");

    // Main scenarios reached
    read_c: cover property (wb_ack_o && !wb_req.we);
    serial_c: cover property (serial_en && port_p_pad.oe[2]);
    t5_c: cover property (timer_t_out.en[5] && pwm_t5_en);
endmodule

bind ppc_port_ctrl ppc_port_chk u_chk
(
    .core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .port_t_pin_in(port_t_pin_in), .port_t_pad(port_t_pad),
    .timer_t_out(timer_t_out), .pwm_t5_en(pwm_t5_en),
    .pwm_t5_val(pwm_t5_val), .port_p_pad(port_p_pad),
    .pwm_p_out(pwm_p_out), .timer_p_oc(timer_p_oc),
    .serial_en(serial_en), .serial_tx_val(serial_tx_val),
    .serial_tx_alt(serial_tx_alt), .serial_rx_alt(serial_rx_alt),
    .peripheral_pin_routing(peripheral_pin_routing),
    .port_t_in_sync(port_t_in_sync),
    .port_p_pin_in(port_p_pin_in), .port_p_in_sync(port_p_in_sync)
);

// ### test/ppc_pad_model.sv
/*
 * External pin model for one 8-bit port.
 * Assumes the bench gives the outside level of every released pin.
 */
`timescale 1ns/100ps
module ppc_pad_model
(
    input  ppc_pkg::ppc_pad_t pad,
    input  logic        [7:0] ext,
    input  logic        [7:0] fault,
    output logic        [7:0] pin
);
    // Driven bits carry the pad value, released ones the outside level;
    // the fault mask shorts pins to ground so faults can be seen
    assign pin = ((pad.oe & pad.out) | (~pad.oe & ext)) & ~fault;
endmodule

// ### test/tb_top.sv
/*
 * Self-checking bench for the port pin control block.
 * Assumes ppc_pkg, ppc_pad_model and the bound checker are compiled.
 */
`timescale 1ns/100ps
module tb_top;
    logic                 core_clk = 1'b0;
    logic                 rst_n;
    ppc_pkg::ppc_wb_req_t wb_req;
    logic          [31:0] wb_dat_o;
    logic                 wb_ack_o;
    ppc_pkg::ppc_pad_t    t_pad, p_pad, m_pad;
    ppc_pkg::ppc_periph_t timer_t_out, pwm_p_out, timer_p_oc, periph_m_out;
    logic           [7:0] t_pin, p_pin, m_pin, ext_t, ext_p, ext_m, fault_t;
    logic           [7:0] routing, t_sync, p_sync;
    logic                 pwm_t5_en, pwm_t5_val, reg_api_val, serial_en;
    logic                 serial_tx_val, tx_alt, rx_alt;
    logic           [1:0] pad_go;
    logic          [31:0] rq[$];
    logic          [31:0] pq[$];
    logic          [31:0] r;
    integer               seed, failures, samples_checked;
    integer               cycles = 0;

    ppc_port_ctrl u_dut
    (
        .core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_t_pin_in(t_pin),
        .port_t_pad(t_pad), .timer_t_out(timer_t_out),
        .pwm_t5_en(pwm_t5_en), .pwm_t5_val(pwm_t5_val),
        .reg_api_val(reg_api_val), .port_p_pin_in(p_pin),
        .port_p_pad(p_pad), .pwm_p_out(pwm_p_out), .timer_p_oc(timer_p_oc),
        .serial_en(serial_en), .serial_tx_val(serial_tx_val),
        .port_m_pin_in(m_pin), .port_m_pad(m_pad),
        .periph_m_out(periph_m_out), .serial_tx_alt(tx_alt),
        .serial_rx_alt(rx_alt), .peripheral_pin_routing(routing),
        .port_t_in_sync(t_sync), .port_p_in_sync(p_sync)
    );
    ppc_pad_model u_pt (.pad(t_pad), .ext(ext_t), .fault(fault_t),
                        .pin(t_pin));
    ppc_pad_model u_pp (.pad(p_pad), .ext(ext_p), .fault(8'h00), .pin(p_pin));
    ppc_pad_model u_pm (.pad(m_pad), .ext(ext_m), .fault(8'h00), .pin(m_pin));

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One classic cycle, held until ack is sampled
    task automatic wb_cyc(input logic [7:0] a, input logic w,
                          input logic [7:0] d);
        @(posedge core_clk);
        wb_req <= '{1'b1, 1'b1, w, 4'h1, a, {24'h0, d}};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        wb_req <= '0;
    endtask

    task automatic wb_wr(input logic [7:0] a, input logic [7:0] d);
        wb_cyc(a, 1'b1, d);
    endtask

    task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb_cyc(a, 1'b0, 8'h00);
    endtask

    // Ask the watcher to look at one pad group
    task automatic pad_chk(input logic [1:0] s, input logic [31:0] e);
        @(posedge core_clk);
        pad_go <= s;
        @(negedge core_clk);
        pq.push_back(e);
        @(posedge core_clk);
        pad_go <= 2'd0;
    endtask

    // Port P drive: PWM, then timer compare, then serial, then register
    function automatic logic [31:0] p_oe(input logic [7:0] d, input logic sh);
        logic [7:0] o;
        o = d;
        if (serial_en)
        begin
            o[2] = 1'b1;
            o[0] = 1'b0;
        end
        o[2:0] = o[2:0] | timer_p_oc.en[2:0];
        o = o | pwm_p_out.en;
        if (sh)
            o[7] = 1'b0;
        return {24'h0, o};
    endfunction

    // Port T with data a5, dir 0f: timer, then PWM, regulator on bit 5
    function automatic logic [31:0] t_exp(input logic rg);
        logic [7:0] oe;
        logic [7:0] v;
        oe = 8'h0f | timer_t_out.en;
        v = (timer_t_out.en & timer_t_out.val) | (~timer_t_out.en & 8'ha5);
        if (!timer_t_out.en[5] && (pwm_t5_en || rg))
        begin
            oe[5] = 1'b1;
            v[5] = pwm_t5_en ? pwm_t5_val : reg_api_val;
        end
        return {16'h0, oe, v & oe};
    endfunction

    // Port M data 5a, dir f0; open-drain bits release a driven one
    function automatic logic [31:0] m_exp(input logic [7:0] od);
        logic [7:0] v;
        logic [7:0] oe;
        v = (periph_m_out.en & periph_m_out.val) | (~periph_m_out.en & 8'h5a);
        oe = (periph_m_out.en | 8'hf0) & ~(od & v);
        return {16'h0, oe, v & ~od & oe};
    endfunction

    // Watcher: oldest note against each result that appears
    always @(posedge core_clk)
    begin
        if (wb_ack_o === 1'b1 && wb_req.we === 1'b0)
            check(wb_dat_o, rq.pop_front());
        case (pad_go)
            2'd1: check({16'h0, t_pad.oe, t_pad.out & t_pad.oe},
                        pq.pop_front());
            2'd2: check({24'h0, p_pad.oe}, pq.pop_front());
            2'd3: check({16'h0, m_pad.oe, m_pad.out & m_pad.oe},
                        pq.pop_front());
            default: ;
        endcase
    end

    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        seed = 73;
        failures = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        wb_req = '0;
        pad_go = 2'd0;
        {timer_t_out, pwm_p_out, timer_p_oc, periph_m_out} = 64'h0;
        {pwm_t5_en, pwm_t5_val, reg_api_val, serial_en, serial_tx_val} = 5'h0;
        {ext_t, ext_p, ext_m, fault_t} = 32'h0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values, up to one unmapped address
        for (int a = 0; a <= 40; a += 4)
            wb_rd(8'(a), 32'h0);
        // Port T: low nibble output, bit 0 shorted low outside
        wb_wr(ppc_pkg::OFS_PORT_T_DATA, 8'ha5);
        wb_wr(ppc_pkg::OFS_PORT_T_DIR, 8'h0f);
        @(posedge core_clk);
        ext_t <= 8'h3c;
        fault_t <= 8'h01;
        repeat (4) @(posedge core_clk);
        pad_chk(2'd1, 32'h0f05);
        wb_rd(ppc_pkg::OFS_PORT_T_DATA, 32'h35);
        wb_rd(ppc_pkg::OFS_PORT_T_INPUT, 32'h34);
        wb_wr(ppc_pkg::OFS_PORT_T_INPUT, 8'hff);
        wb_rd(ppc_pkg::OFS_PORT_T_INPUT, 32'h34);
        wb_rd(ppc_pkg::OFS_PORT_T_DATA, 32'h35);
        wb_wr(ppc_pkg::OFS_ROUTING, 8'hc3);
        wb_rd(ppc_pkg::OFS_ROUTING, 32'hc3);
        wb_wr(ppc_pkg::OFS_PORT_M_DATA, 8'h5a);
        wb_wr(ppc_pkg::OFS_PORT_M_DIR, 8'hf0);
        // Random directions, overrides and open-drain selections
        for (int i = 0; i < 24; i++)
        begin
            r = $random(seed);
            wb_wr(ppc_pkg::OFS_PORT_P_DIR, r[7:0]);
            wb_wr(ppc_pkg::OFS_PERIPH_CTRL, {5'h0, r[10:8]});
            wb_wr(ppc_pkg::OFS_PORT_M_OD, r[23:16]);
            @(posedge core_clk);
            // First rounds clear the timer and port P PWM enables so serial and the bit 5 PWM or regulator win
            {pwm_p_out, timer_p_oc} <= $random(seed)
                & (i < 4 ? 32'h00ff_00ff : 32'hffff_ffff);
            {periph_m_out, timer_t_out} <= $random(seed)
                & (i < 4 ? 32'hffff_00ff : 32'hffff_ffff);
            {pwm_t5_en, pwm_t5_val, reg_api_val} <= r[27:25];
            serial_en <= r[24] || i < 4;
            serial_tx_val <= r[28];
            ext_p <= r[15:8];
            ext_m <= r[31:24];
            @(negedge core_clk);
            pad_chk(2'd2, p_oe(r[7:0], r[9]));
            pad_chk(2'd3, m_exp(r[23:16]));
            pad_chk(2'd1, t_exp(r[8]));
            wb_rd(ppc_pkg::OFS_PORT_P_DIR, {24'h0, r[7:0]});
        end
        final_report();
    end
endmodule
